// ===== include/interval_pwm_pkg.sv
package interval_pwm_pkg;
   localparam int CNT_W = 8;
   localparam int PRE_W = 12;
   localparam int SLOW_W = 7;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [CNT_W-1:0] DUTY_RST = 8'h00;
   localparam logic [1:0] MODE_INTERVAL = 2'h0;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [2:0] CKS_DIV1 = 3'h0;
   localparam logic [2:0] CKS_DIV4 = 3'h1;
   localparam logic [2:0] CKS_DIV16 = 3'h2;
   localparam logic [2:0] CKS_DIV64 = 3'h3;
   localparam logic [2:0] CKS_DIV4096 = 3'h4;
   localparam logic [2:0] CKS_SLOW128 = 3'h5;
   localparam logic [PRE_W-1:0] MASK_DIV1 = 12'h000;
   localparam logic [PRE_W-1:0] MASK_DIV4 = 12'h003;
   localparam logic [PRE_W-1:0] MASK_DIV16 = 12'h00F;
   localparam logic [PRE_W-1:0] MASK_DIV64 = 12'h03F;
   localparam logic [PRE_W-1:0] MASK_DIV4096 = 12'hFFF;
   localparam logic [SLOW_W-1:0] SLOW_LAST = 7'h7F;
   localparam logic [1:0] DUTY_SETTLE_TICKS = 2'h3;
   typedef enum logic [0:0] {CMP_PERIOD = 1'b0, CMP_DUTY = 1'b1} cmp_sel_e;
endpackage : interval_pwm_pkg

// ===== logic/count_clock_gen.sv
module count_clock_gen (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [2:0] clock_sel,
   input wire logic slow_osc_tick,
   output logic count_tick
);
   typedef struct packed {
      logic [interval_pwm_pkg::PRE_W-1:0] pre;
      logic [interval_pwm_pkg::SLOW_W-1:0] slow;
   } gen_s;
   gen_s st_r;
   gen_s st_nxt;
   logic [interval_pwm_pkg::PRE_W-1:0] mask;
   // free running so the first tick after enable comes within one count clock
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.pre = st_r.pre + 12'h001;
      if (slow_osc_tick)
      begin
         st_nxt.slow = st_r.slow + 7'h01;
      end
      mask = interval_pwm_pkg::MASK_DIV1;
      count_tick = 1'b0;
      unique case (clock_sel)
         interval_pwm_pkg::CKS_DIV1: count_tick = 1'b1;
         interval_pwm_pkg::CKS_DIV4: mask = interval_pwm_pkg::MASK_DIV4;
         interval_pwm_pkg::CKS_DIV16: mask = interval_pwm_pkg::MASK_DIV16;
         interval_pwm_pkg::CKS_DIV64: mask = interval_pwm_pkg::MASK_DIV64;
         interval_pwm_pkg::CKS_DIV4096: mask = interval_pwm_pkg::MASK_DIV4096;
         interval_pwm_pkg::CKS_SLOW128: count_tick = slow_osc_tick && (st_r.slow == interval_pwm_pkg::SLOW_LAST);
         default: count_tick = 1'b0; // prohibited codes never tick
      endcase
      if ((clock_sel >= interval_pwm_pkg::CKS_DIV4) && (clock_sel <= interval_pwm_pkg::CKS_DIV4096))
      begin
         count_tick = ((st_r.pre & mask) == mask);
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
endmodule : count_clock_gen

// ===== logic/duty_buffer.sv
module duty_buffer (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic running,
   input wire logic count_tick,
   input wire logic duty_write,
   input wire logic [7:0] duty_compare,
   input wire logic duty_hit,
   output logic [7:0] duty_active
);
   typedef struct packed {
      logic [7:0] active;
      logic [7:0] pending;
      logic waiting;
      logic [1:0] age;
   } buf_s;
   buf_s st_r;
   buf_s st_nxt;
   always_comb
   begin
      st_nxt = st_r;
      if (count_tick && (st_r.age != interval_pwm_pkg::DUTY_SETTLE_TICKS))
      begin
         st_nxt.age = st_r.age + 2'h1;
      end
      // a match too soon after the write leaves the value waiting
      if (duty_hit && st_r.waiting && (st_r.age == interval_pwm_pkg::DUTY_SETTLE_TICKS))
      begin
         st_nxt.active = st_r.pending;
         st_nxt.waiting = 1'b0;
      end
      // write wins over a same-cycle match, so it waits for a later one
      if (duty_write)
      begin
         st_nxt.pending = duty_compare;
         st_nxt.age = 2'h0;
         st_nxt.waiting = running;
         // a same-cycle transfer is dropped; only the newest write waits
         st_nxt.active = running ? st_r.active : duty_compare;
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         st_r <= '{active: interval_pwm_pkg::DUTY_RST, pending: interval_pwm_pkg::DUTY_RST, waiting: 1'b0, age: 2'h0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign duty_active = st_r.active;
endmodule : duty_buffer

// ===== logic/interval_pwm_timer.sv
module interval_pwm_timer (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic count_run_bit,
   input wire logic op_mode_bit1,
   input wire logic op_mode_bit0,
   input wire logic clock_select_bit2,
   input wire logic clock_select_bit1,
   input wire logic clock_select_bit0,
   input wire logic out_default_level,
   input wire logic out_drive_enable,
   input wire logic slow_osc_tick,
   input wire logic [7:0] period_compare,
   input wire logic [7:0] duty_compare,
   input wire logic duty_write,
   output logic match_irq,
   output logic timer_out_pin,
   output logic [7:0] count_value,
   output logic [7:0] duty_active
);
   typedef struct packed {
      logic [7:0] cnt;
      interval_pwm_pkg::cmp_sel_e cmp;
      logic active;
      logic irq;
      logic mask_first;
      logic pin;
   } tmr_s;
   tmr_s st_r;
   tmr_s st_nxt;
   logic [1:0] mode;
   logic mode_int;
   logic mode_pwm;
   logic running;
   logic count_tick;
   logic period_hit;
   logic duty_hit;

   assign mode = {op_mode_bit1, op_mode_bit0};
   assign mode_int = (mode == interval_pwm_pkg::MODE_INTERVAL);
   assign mode_pwm = (mode == interval_pwm_pkg::MODE_PWM);
   // prohibited mode codes simply hold the counter stopped
   assign running = count_run_bit && (mode_int || mode_pwm);

   count_clock_gen u_clk_gen (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clock_sel({clock_select_bit2, clock_select_bit1, clock_select_bit0}),
      .slow_osc_tick(slow_osc_tick),
      .count_tick(count_tick)
   );

   // compare every count clock but the first after start against the selected register
   assign period_hit = running && count_tick && !st_r.mask_first
                       && (st_r.cmp == interval_pwm_pkg::CMP_PERIOD) && (st_r.cnt == period_compare);
   assign duty_hit = running && mode_pwm && count_tick && !st_r.mask_first
                     && (st_r.cmp == interval_pwm_pkg::CMP_DUTY) && (st_r.cnt == duty_active);

   duty_buffer u_duty (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .running(running),
      .count_tick(count_tick),
      .duty_write(duty_write),
      .duty_compare(duty_compare),
      .duty_hit(duty_hit),
      .duty_active(duty_active)
   );

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.irq = 1'b0;
      if (!running)
      begin
         // stop clears counter, pulse and active state, so the pin returns to its idle level; pwm will mask again
         st_nxt.cnt = interval_pwm_pkg::CNT_RST;
         st_nxt.cmp = interval_pwm_pkg::CMP_PERIOD;
         st_nxt.active = 1'b0;
         st_nxt.mask_first = 1'b1;
      end
      else if (count_tick)
      begin
         if (st_r.mask_first && mode_pwm)
         begin
            st_nxt.mask_first = 1'b0;
         end
         else if (period_hit)
         begin
            st_nxt.cnt = interval_pwm_pkg::CNT_RST;
            st_nxt.irq = 1'b1;
            st_nxt.mask_first = 1'b0;
            if (mode_pwm)
            begin
               st_nxt.active = 1'b1;
               st_nxt.cmp = interval_pwm_pkg::CMP_DUTY;
            end
            else
            begin
               st_nxt.active = !st_r.active;
            end
         end
         else if (duty_hit)
         begin
            st_nxt.cnt = st_r.cnt + 8'h01;
            st_nxt.active = 1'b0;
            st_nxt.cmp = interval_pwm_pkg::CMP_PERIOD;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt + 8'h01;
            st_nxt.mask_first = 1'b0;
         end
      end
      // idle level from the default bit, gated by drive enable
      st_nxt.pin = out_drive_enable && (st_nxt.active ^ out_default_level);
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         st_r <= '{cnt: interval_pwm_pkg::CNT_RST, cmp: interval_pwm_pkg::CMP_PERIOD, active: 1'b0,
                   irq: 1'b0, mask_first: 1'b1, pin: 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign match_irq = st_r.irq;
   assign timer_out_pin = st_r.pin;
   assign count_value = st_r.cnt;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   sequence seq_period_match;
      period_hit && running;
   endsequence

   sequence seq_duty_match;
      duty_hit;
   endsequence

   sequence seq_plain_step;
      running && count_tick && !st_r.mask_first && !period_hit && !duty_hit;
   endsequence

   a_interval_clear: assert property (seq_period_match ##0 mode_int |=> (count_value == 8'h00) && match_irq)
      else $error("interval match did not clear counter and pulse");

   a_interval_toggle: assert property (seq_period_match ##0 mode_int |=> st_r.active != $past(st_r.active))
      else $error("interval match did not toggle output");

   a_stop_quiet: assert property (!count_run_bit |=> !match_irq && !st_r.active && count_value == 8'h00)
      else $error("stopped timer not inactive and cleared");

   a_pwm_period: assert property (seq_period_match ##0 mode_pwm
                                  |=> match_irq && st_r.active && st_r.cmp == interval_pwm_pkg::CMP_DUTY)
      else $error("pwm period match wrong");

   a_pwm_duty: assert property (seq_duty_match
                                |=> !match_irq && !st_r.active && st_r.cmp == interval_pwm_pkg::CMP_PERIOD
                                && count_value == 8'($past(count_value) + 8'h01))
      else $error("pwm duty match wrong");

   a_pwm_mask: assert property (running && mode_pwm && count_tick && st_r.mask_first
                                |=> count_value == 8'h00 && !st_r.active)
      else $error("first pwm count clock not masked");

   a_count_step: assert property (seq_plain_step |=> count_value == 8'($past(count_value) + 8'h01))
      else $error("counter did not step by one");

   a_count_hold: assert property (running && !count_tick && count_run_bit |=> $stable(count_value))
      else $error("counter moved without count clock");

   a_duty_latched: assert property (running && duty_write |=> $stable(duty_active))
      else $error("duty value changed on a running write");

   a_pin_idle: assert property (!out_drive_enable |=> !timer_out_pin)
      else $error("disabled output driven");

   a_stop_level: assert property (!count_run_bit && out_drive_enable ##1 out_drive_enable
                                  |-> timer_out_pin == $past(out_default_level))
      else $error("stopped output not at default level");
endmodule : interval_pwm_timer

// ===== verification/eight_bit_interval_pwm_timer_test.sv
module eight_bit_interval_pwm_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic count_run_bit = 1'b0;
   logic op_mode_bit1 = 1'b0;
   logic op_mode_bit0 = 1'b0;
   logic clock_select_bit2 = 1'b0;
   logic clock_select_bit1 = 1'b0;
   logic clock_select_bit0 = 1'b0;
   logic out_default_level = 1'b0;
   logic out_drive_enable = 1'b1;
   logic slow_osc_tick = 1'b0;
   logic [7:0] period_compare = 8'h00;
   logic [7:0] duty_compare = 8'h00;
   logic duty_write = 1'b0;
   logic match_irq;
   logic timer_out_pin;
   logic [7:0] count_value;
   logic [7:0] duty_active;
   int errors = 0;
   int cmp_count = 0;
   int slow_div = 0;
   int n;
   int hi;

   interval_pwm_timer i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .count_run_bit(count_run_bit),
      .op_mode_bit1(op_mode_bit1), .op_mode_bit0(op_mode_bit0), .clock_select_bit2(clock_select_bit2),
      .clock_select_bit1(clock_select_bit1), .clock_select_bit0(clock_select_bit0),
      .out_default_level(out_default_level), .out_drive_enable(out_drive_enable),
      .slow_osc_tick(slow_osc_tick), .period_compare(period_compare), .duty_compare(duty_compare),
      .duty_write(duty_write), .match_irq(match_irq), .timer_out_pin(timer_out_pin),
      .count_value(count_value), .duty_active(duty_active));

   always #12.5 ref_clk = ~ref_clk;

   // slow oscillator stand-in: one pulse every third cycle
   always @(posedge ref_clk)
   begin
      slow_div <= (slow_div == 2) ? 0 : slow_div + 1;
      slow_osc_tick <= (slow_div == 2);
   end

   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task step(input int k);
      repeat (k)
      begin
         @(posedge ref_clk);
         #1;
      end
   endtask : step

   // cycles up to and including the next match pulse, and pin-high cycles among them
   task wait_irq(input int lim, output int cnt, output int high);
      cnt = 0;
      high = 0;
      do
      begin
         step(1);
         cnt++;
         if (timer_out_pin === 1'b1)
            high++;
      end
      while (match_irq !== 1'b1 && cnt < lim);
   endtask : wait_irq

   task setup(input logic [1:0] mode, input logic [2:0] cks, input logic [7:0] per, input logic [7:0] duty);
      @(posedge ref_clk);
      count_run_bit <= 1'b0;
      {op_mode_bit1, op_mode_bit0} <= mode;
      {clock_select_bit2, clock_select_bit1, clock_select_bit0} <= cks;
      period_compare <= per;
      duty_compare <= duty;
      duty_write <= 1'b1;
      @(posedge ref_clk);
      duty_write <= 1'b0;
      count_run_bit <= 1'b1;
      #1;
   endtask : setup

   task stop_run();
      @(posedge ref_clk);
      count_run_bit <= 1'b0;
      step(2);
   endtask : stop_run

   task interval_run(input logic [2:0] cks, input logic [7:0] per, input int div);
      logic p;
      setup(interval_pwm_pkg::MODE_INTERVAL, cks, per, 8'h00);
      wait_irq(20000, n, hi);
      check("first interval bound", 16'(n <= div * (per + 2) + 1), 16'h0001);
      check("count after match", count_value, 16'h0000);
      p = timer_out_pin;
      wait_irq(20000, n, hi);
      check("interval length", 16'(n), 16'(div * (per + 1)));
      check("square wave toggle", timer_out_pin, !p);
      step(1);
      check("match pulse width", match_irq, 1'b0);
   endtask : interval_run

   task stop_and_levels();
      stop_run();
      check("stopped pulse", match_irq, 1'b0);
      check("stopped pin", timer_out_pin, 1'b0);
      check("stopped count", count_value, 16'h0000);
      @(posedge ref_clk);
      out_default_level <= 1'b1;
      step(2);
      check("idle high level", timer_out_pin, 1'b1);
      @(posedge ref_clk);
      out_drive_enable <= 1'b0;
      step(2);
      check("output disabled", timer_out_pin, 1'b0);
      @(posedge ref_clk);
      out_default_level <= 1'b0;
      out_drive_enable <= 1'b1;
   endtask : stop_and_levels

   task pwm_run();
      setup(interval_pwm_pkg::MODE_PWM, interval_pwm_pkg::CKS_DIV1, 8'h04, 8'h01);
      wait_irq(100, n, hi);
      check("pin inactive until first match", 16'(hi), 16'h0001);
      check("pin active at period match", timer_out_pin, 1'b1);
      wait_irq(100, n, hi);
      check("pwm period", 16'(n), 16'h0005);
      check("pwm active width", 16'(hi), 16'h0002);
      // strobe taken on the old duty match edge, so the new value waits
      @(posedge ref_clk);
      duty_compare <= 8'h03;
      duty_write <= 1'b1;
      @(posedge ref_clk);
      duty_write <= 1'b0;
      #1;
      check("old duty match on write edge", timer_out_pin, 1'b0);
      // rest of this period: pin low until the closing period match
      wait_irq(100, n, hi);
      check("old duty kept", duty_active, 16'h0001);
      check("old width kept", 16'(hi), 16'h0001);
      wait_irq(100, n, hi);
      check("duty transferred", duty_active, 16'h0003);
      wait_irq(100, n, hi);
      check("new active width", 16'(hi), 16'h0004);
      stop_run();
      check("pwm stop pin", timer_out_pin, 1'b0);
   endtask : pwm_run

   task bad_mode();
      setup(2'b01, interval_pwm_pkg::CKS_DIV1, 8'h02, 8'h00);
      wait_irq(50, n, hi);
      check("prohibited mode runs", 16'(n), 16'd50);
      check("prohibited mode count", count_value, 16'h0000);
      setup(interval_pwm_pkg::MODE_INTERVAL, 3'h6, 8'h02, 8'h00);
      wait_irq(50, n, hi);
      check("prohibited clock runs", 16'(n), 16'h0032);
      check("prohibited clock count", count_value, 16'h0000);
      stop_run();
   endtask : bad_mode

   task conclude();
      if (errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      step(1);
      check("reset pulse", match_irq, 1'b0);
      check("reset pin", timer_out_pin, 1'b0);
      check("reset count", count_value, 16'h0000);
      interval_run(interval_pwm_pkg::CKS_DIV1, 8'h02, 1);
      stop_and_levels();
      interval_run(interval_pwm_pkg::CKS_DIV1, 8'hFE, 1);
      interval_run(interval_pwm_pkg::CKS_DIV4, 8'h01, 4);
      interval_run(interval_pwm_pkg::CKS_DIV16, 8'h01, 16);
      interval_run(interval_pwm_pkg::CKS_DIV64, 8'h01, 64);
      interval_run(interval_pwm_pkg::CKS_DIV4096, 8'h01, 4096);
      interval_run(interval_pwm_pkg::CKS_SLOW128, 8'h01, 384);
      stop_run();
      pwm_run();
      bad_mode();
      conclude();
   end

   // run needs about 18k cycles; 80k leaves margin
   initial
   begin
      #2ms;
      errors++;
      conclude();
   end
endmodule : eight_bit_interval_pwm_timer_test
